// file: logic/opdec_pkg.sv
// opdec_pkg: opcode patterns, field positions, word and cycle counts for the decoder
// assumes 16-bit instruction words from program memory
package opdec_pkg;
  // field positions
  localparam int SHIFT_LSB   = 8;
  localparam int SHIFT_W     = 4;
  localparam int IMM_W       = 8;
  localparam int COND_MASK_W = 4;
  localparam int SEL_LSB     = 10;
  localparam int CMP_W       = 2;
  // full opcodes
  localparam logic [15:0] OP_MAGNITUDE  = 16'hbe00;
  localparam logic [15:0] OP_PRODUCT    = 16'hbe04;
  localparam logic [15:0] OP_ACC_BRANCH = 16'hbe20;
  localparam logic [15:0] OP_AND_HI16   = 16'hbe81;
  // upper bytes
  localparam logic [7:0] UB_ADD_HIGH   = 8'h61;
  localparam logic [7:0] UB_ADD_IMM    = 8'hb8;
  localparam logic [7:0] UB_ADD_CARRY  = 8'h60;
  localparam logic [7:0] UB_ADD_LOW    = 8'h62;
  localparam logic [7:0] UB_ADD_TSHIFT = 8'h63;
  localparam logic [7:0] UB_AUX_OFFSET = 8'h78;
  localparam logic [7:0] UB_AND_MEM    = 8'h6e;
  localparam logic [7:0] UB_AUX_LOOP   = 8'h7b;
  localparam logic [7:0] UB_DYN_TEST   = 8'h6f;
  localparam logic [7:0] UB_COPY_SRC   = 8'ha8;
  localparam logic [7:0] UB_COPY_DST   = 8'ha9;
  localparam logic [7:0] UB_PORT_READ  = 8'haf;
  localparam logic [7:0] UB_COND_ACC   = 8'he3;
  // twelve-bit prefixes with shift field, then the fourteen-bit compare prefix
  localparam logic [11:0] P12_ADD_LONG = 12'hbf9;
  localparam logic [11:0] P12_AND_LONG = 12'hbfb;
  localparam logic [13:0] P14_COMPARE  = 14'h2fd1; // 1011 1111 0100 01
  // top nibbles
  localparam logic [3:0] TN_ADD_SHIFT = 4'h2;
  localparam logic [3:0] TN_BIT_TEST  = 4'h4;
  localparam logic [3:0] TN_BRANCH    = 4'he;
  // selector pair codes
  localparam logic [1:0] SEL_PIN_LOW = 2'h0;
  localparam logic [1:0] SEL_TF_SET  = 2'h1;
  localparam logic [1:0] SEL_TF_CLR  = 2'h2;
  localparam logic [1:0] SEL_NONE    = 2'h3;
  // word and cycle counts
  localparam logic [1:0] WORDS_ONE = 2'h1;
  localparam logic [1:0] WORDS_TWO = 2'h2;
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  // operation classes
  typedef enum logic [4:0] {
    OPC_NONE, OPC_MAGNITUDE, OPC_ADD_SHIFT, OPC_ADD_HIGH, OPC_ADD_IMM, OPC_ADD_LONG,
    OPC_SUM_CARRY, OPC_SUM_LOW, OPC_SUM_TSHIFT, OPC_AUX_OFFSET, OPC_AND_MEM,
    OPC_AND_LONG, OPC_AND_HI16, OPC_PRODUCT_ACC, OPC_ACC_BRANCH, OPC_AUX_LOOP,
    OPC_COND_BRANCH, OPC_DYN_TEST, OPC_BIT_TEST, OPC_COPY_SRC, OPC_COPY_DST,
    OPC_AUX_COMPARE, OPC_PORT_READ
  } op_class_e;
endpackage : opdec_pkg

// file: logic/cond_eval.sv
// cond_eval: evaluates the accumulator condition field and selector pair
// assumes all flags come from logic on the same clock
`timescale 1ns/1ns
module cond_eval
(
  // condition fields from the instruction
  input  wire logic [3:0] cond_mask,
  input  wire logic [3:0] cond_state,
  input  wire logic [1:0] sel_pair,
  // status flags
  input  wire logic       acc_zero,
  input  wire logic       acc_neg,
  input  wire logic       ovf,
  input  wire logic       carry,
  input  wire logic       test_flag,
  input  wire logic       pin_low,
  // result
  output logic            cond_true
);
  logic [3:0] status_vec;
  logic       acc_ok;
  logic       pair_ok;
  logic       pair_used;
  // z l v c from msb to lsb
  assign status_vec = {acc_zero, acc_neg, ovf, carry};
  // a tested condition is met when any masked bit matches its wanted state
  assign acc_ok    = |(cond_mask & ~(status_vec ^ cond_state));
  assign pair_used = (sel_pair != opdec_pkg::SEL_NONE);
  // selector pair: pin low, flag set, flag clear, none
  assign pair_ok   = (sel_pair == opdec_pkg::SEL_PIN_LOW) ? pin_low :
                     (sel_pair == opdec_pkg::SEL_TF_SET)  ? test_flag :
                     (sel_pair == opdec_pkg::SEL_TF_CLR)  ? ~test_flag : 1'b0;
  assign cond_true = (pair_used && pair_ok) || ((cond_mask != 4'h0) && acc_ok);
endmodule : cond_eval

// file: logic/opcode_decoder.sv
// opcode_decoder: decodes the first part of the instruction set into controls
// assumes program memory presents one word per word_valid pulse on ref_clk;
// the external branch pin is asynchronous and is synchronised here
`timescale 1ns/1ns
module opcode_decoder
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // program memory words
  input  wire logic [15:0] instr_word,
  input  wire logic        word_valid,
  // status flags from the datapath
  input  wire logic        acc_zero,
  input  wire logic        acc_neg,
  input  wire logic        ovf,
  input  wire logic        carry,
  input  wire logic        test_flag,
  input  wire logic        aux_nonzero,
  // external branch pin, asynchronous
  input  wire logic        branch_pin,
  // decoded controls
  output opdec_pkg::op_class_e op_class_q,
  output logic             dec_valid_q,
  output logic [1:0]       word_count_q,
  output logic [2:0]       cycle_count_q,
  output logic             branch_taken_q,
  output logic [3:0]       shift_q,
  output logic [7:0]       imm_q,
  output logic             indirect_q,
  output logic [6:0]       addr_q,
  output logic [15:0]      operand_q,
  output logic [3:0]       bit_sel_q,
  output logic [1:0]       compare_sel_q,
  output logic             sets_test_flag_q
);
  typedef enum logic [0:0] {ST_FETCH, ST_OPERAND} fetch_state_e;
  fetch_state_e st_q;
  fetch_state_e st_d;
  logic [15:0] held_q;
  logic        pin_meta_q;
  logic        pin_sync_q;
  // field views of the fresh word
  wire  [7:0]  ub  = instr_word[15:8];
  wire  [3:0]  tn  = instr_word[15:12];
  wire  [11:0] p12 = instr_word[15:4];
  // first-word classification
  opdec_pkg::op_class_e cls;
  logic two_word;
  assign cls =
    (instr_word == opdec_pkg::OP_MAGNITUDE)  ? opdec_pkg::OPC_MAGNITUDE :
    (instr_word == opdec_pkg::OP_PRODUCT)    ? opdec_pkg::OPC_PRODUCT_ACC :
    (instr_word == opdec_pkg::OP_ACC_BRANCH) ? opdec_pkg::OPC_ACC_BRANCH :
    (instr_word == opdec_pkg::OP_AND_HI16)   ? opdec_pkg::OPC_AND_HI16 :
    (p12 == opdec_pkg::P12_ADD_LONG)         ? opdec_pkg::OPC_ADD_LONG :
    (p12 == opdec_pkg::P12_AND_LONG)         ? opdec_pkg::OPC_AND_LONG :
    (instr_word[15:2] == opdec_pkg::P14_COMPARE) ? opdec_pkg::OPC_AUX_COMPARE :
    (ub == opdec_pkg::UB_ADD_HIGH)   ? opdec_pkg::OPC_ADD_HIGH :
    (ub == opdec_pkg::UB_ADD_IMM)    ? opdec_pkg::OPC_ADD_IMM :
    (ub == opdec_pkg::UB_ADD_CARRY)  ? opdec_pkg::OPC_SUM_CARRY :
    (ub == opdec_pkg::UB_ADD_LOW)    ? opdec_pkg::OPC_SUM_LOW :
    (ub == opdec_pkg::UB_ADD_TSHIFT) ? opdec_pkg::OPC_SUM_TSHIFT :
    (ub == opdec_pkg::UB_AUX_OFFSET) ? opdec_pkg::OPC_AUX_OFFSET :
    (ub == opdec_pkg::UB_AND_MEM)    ? opdec_pkg::OPC_AND_MEM :
    (ub == opdec_pkg::UB_AUX_LOOP)   ? opdec_pkg::OPC_AUX_LOOP :
    (ub == opdec_pkg::UB_DYN_TEST)   ? opdec_pkg::OPC_DYN_TEST :
    (ub == opdec_pkg::UB_COPY_SRC)   ? opdec_pkg::OPC_COPY_SRC :
    (ub == opdec_pkg::UB_COPY_DST)   ? opdec_pkg::OPC_COPY_DST :
    (ub == opdec_pkg::UB_PORT_READ)  ? opdec_pkg::OPC_PORT_READ :
    (tn == opdec_pkg::TN_BRANCH && instr_word[11:10] == 2'h0)
                                     ? opdec_pkg::OPC_COND_BRANCH :
    (tn == opdec_pkg::TN_ADD_SHIFT)  ? opdec_pkg::OPC_ADD_SHIFT :
    (tn == opdec_pkg::TN_BIT_TEST)   ? opdec_pkg::OPC_BIT_TEST :
                                       opdec_pkg::OPC_NONE;
  // two-word forms
  assign two_word = (cls == opdec_pkg::OPC_ADD_LONG) || (cls == opdec_pkg::OPC_AND_LONG) ||
                    (cls == opdec_pkg::OPC_AND_HI16) || (cls == opdec_pkg::OPC_AUX_LOOP) ||
                    (cls == opdec_pkg::OPC_COND_BRANCH) || (cls == opdec_pkg::OPC_COPY_SRC) ||
                    (cls == opdec_pkg::OPC_COPY_DST) || (cls == opdec_pkg::OPC_PORT_READ);
  // the class of the word being finished
  opdec_pkg::op_class_e fin_cls;
  logic [15:0] fin_word;
  assign fin_word = (st_q == ST_OPERAND) ? held_q : instr_word;
  opdec_pkg::op_class_e held_cls_q;
  assign fin_cls  = (st_q == ST_OPERAND) ? held_cls_q : cls;
  // condition evaluation on the held first word
  logic cond_true;
  cond_eval u_cond
  (
    .cond_mask  (fin_word[3:0]),
    .cond_state (fin_word[7:4]),
    .sel_pair   (fin_word[9:8]),
    .acc_zero   (acc_zero),
    .acc_neg    (acc_neg),
    .ovf        (ovf),
    .carry      (carry),
    .test_flag  (test_flag),
    .pin_low    (~pin_sync_q),
    .cond_true  (cond_true)
  );
  // branch outcome and cycle count
  logic taken;
  logic [2:0] cycles;
  logic is_pin_branch;
  assign is_pin_branch = (fin_cls == opdec_pkg::OPC_COND_BRANCH) &&
                         (fin_word[9:8] == opdec_pkg::SEL_PIN_LOW) && (fin_word[7:0] == 8'h00);
  assign taken = (fin_cls == opdec_pkg::OPC_ACC_BRANCH) ||
                 ((fin_cls == opdec_pkg::OPC_AUX_LOOP) && aux_nonzero) ||
                 ((fin_cls == opdec_pkg::OPC_COND_BRANCH) && cond_true);
  assign cycles =
    (fin_cls == opdec_pkg::OPC_ACC_BRANCH) ? opdec_pkg::CYC_4 :
    (fin_cls == opdec_pkg::OPC_AUX_LOOP || fin_cls == opdec_pkg::OPC_COND_BRANCH)
      ? (taken ? opdec_pkg::CYC_4 :
         (is_pin_branch ? opdec_pkg::CYC_3 : opdec_pkg::CYC_2)) :
    (fin_cls == opdec_pkg::OPC_COPY_SRC || fin_cls == opdec_pkg::OPC_COPY_DST)
      ? opdec_pkg::CYC_3 :
    (fin_cls == opdec_pkg::OPC_ADD_LONG || fin_cls == opdec_pkg::OPC_AND_LONG ||
     fin_cls == opdec_pkg::OPC_AND_HI16 || fin_cls == opdec_pkg::OPC_PORT_READ)
      ? opdec_pkg::CYC_2 : opdec_pkg::CYC_1;
  // sequencing: a two-word first word waits for its operand word
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_FETCH:   if (word_valid && two_word) st_d = ST_OPERAND;
      ST_OPERAND: if (word_valid) st_d = ST_FETCH;
      default:    st_d = ST_FETCH;
    endcase
  end
  logic fire;
  assign fire = word_valid && ((st_q == ST_OPERAND) || !two_word);
  // pin synchroniser
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end
    else
    begin
      pin_meta_q <= branch_pin;
      pin_sync_q <= pin_meta_q;
    end
  end
  // state and held first word
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q       <= ST_FETCH;
      held_q     <= 16'h0000;
      held_cls_q <= opdec_pkg::OPC_NONE;
    end
    else
    begin
      st_q <= st_d;
      if (word_valid && st_q == ST_FETCH)
      begin
        held_q     <= instr_word;
        held_cls_q <= cls;
      end
    end
  end
  // decoded outputs, one pulse of dec_valid_q per instruction
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dec_valid_q      <= 1'b0;
      op_class_q       <= opdec_pkg::OPC_NONE;
      word_count_q     <= 2'h0;
      cycle_count_q    <= 3'h0;
      branch_taken_q   <= 1'b0;
      shift_q          <= 4'h0;
      imm_q            <= 8'h00;
      indirect_q       <= 1'b0;
      addr_q           <= 7'h00;
      operand_q        <= 16'h0000;
      bit_sel_q        <= 4'h0;
      compare_sel_q    <= 2'h0;
      sets_test_flag_q <= 1'b0;
    end
    else
    begin
      dec_valid_q <= fire;
      if (fire)
      begin
        op_class_q     <= fin_cls;
        word_count_q   <= (st_q == ST_OPERAND) ? opdec_pkg::WORDS_TWO : opdec_pkg::WORDS_ONE;
        cycle_count_q  <= cycles;
        branch_taken_q <= taken;
        shift_q        <= (fin_cls == opdec_pkg::OPC_ADD_SHIFT) ? fin_word[11:8] :
                          fin_word[3:0];
        imm_q          <= fin_word[7:0];
        indirect_q     <= fin_word[7];
        addr_q         <= fin_word[6:0];
        operand_q      <= (st_q == ST_OPERAND) ? instr_word : 16'h0000;
        bit_sel_q      <= fin_word[11:8];
        compare_sel_q  <= fin_word[1:0];
        sets_test_flag_q <= (fin_cls == opdec_pkg::OPC_BIT_TEST) ||
                            (fin_cls == opdec_pkg::OPC_DYN_TEST) ||
                            (fin_cls == opdec_pkg::OPC_AUX_COMPARE);
      end
    end
  end
  // assertions
  a_magnitude_one_cycle: assert property (@(posedge ref_clk) disable iff (rst)
    (word_valid && st_q == ST_FETCH && instr_word == opdec_pkg::OP_MAGNITUDE) |=>
    (dec_valid_q && cycle_count_q == 3'h1 && word_count_q == 2'h1))
    else $error("magnitude op miscounted");
  a_acc_branch_four: assert property (@(posedge ref_clk) disable iff (rst)
    (word_valid && st_q == ST_FETCH && instr_word == opdec_pkg::OP_ACC_BRANCH) |=>
    (cycle_count_q == 3'h4 && branch_taken_q))
    else $error("accumulator branch miscounted");
  a_two_word_waits: assert property (@(posedge ref_clk) disable iff (rst)
    (word_valid && st_q == ST_FETCH && two_word) |=> !dec_valid_q && st_q == ST_OPERAND)
    else $error("first word decoded early");
  a_operand_captured: assert property (@(posedge ref_clk) disable iff (rst)
    (word_valid && st_q == ST_OPERAND) |=>
    (dec_valid_q && word_count_q == 2'h2 && operand_q == $past(instr_word)))
    else $error("operand word lost");
  a_copy_three: assert property (@(posedge ref_clk) disable iff (rst)
    (dec_valid_q && (op_class_q == opdec_pkg::OPC_COPY_SRC ||
     op_class_q == opdec_pkg::OPC_COPY_DST)) |-> cycle_count_q == 3'h3)
    else $error("copy cycle count wrong");
  a_loop_not_taken: assert property (@(posedge ref_clk) disable iff (rst)
    (dec_valid_q && op_class_q == opdec_pkg::OPC_AUX_LOOP) |->
    (branch_taken_q ? cycle_count_q == 3'h4 : cycle_count_q == 3'h2))
    else $error("aux loop branch cycles wrong");
  a_add_long_two: assert property (@(posedge ref_clk) disable iff (rst)
    (dec_valid_q && op_class_q == opdec_pkg::OPC_ADD_LONG) |->
    (cycle_count_q == 3'h2 && word_count_q == 2'h2))
    else $error("long add miscounted");
  a_port_read_two: assert property (@(posedge ref_clk) disable iff (rst)
    (dec_valid_q && op_class_q == opdec_pkg::OPC_PORT_READ) |-> cycle_count_q == 3'h2)
    else $error("port read miscounted");
  a_test_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
    (dec_valid_q && op_class_q == opdec_pkg::OPC_BIT_TEST) |-> sets_test_flag_q)
    else $error("bit test does not mark flag");
endmodule : opcode_decoder

// file: bench/prog_mem_model.sv
// prog_mem_model: program memory that hands queued words to the decoder
// assumes the bench queues words with push and sets stall for a slow memory
`timescale 1ns/1ns
module prog_mem_model
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // word bus toward the decoder
  output logic [15:0]      instr_word,
  output logic             word_valid
);
  logic [15:0] fifo_q[$];
  int          stall;
  int          wait_n;

  // quiet bus before the first edge
  initial
  begin
    instr_word = 16'h0000;
    word_valid = 1'b0;
    stall      = 0;
    wait_n     = 0;
  end

  // bench entry point: an operand word is queued right after its first word
  task automatic push(input logic [15:0] w);
    fifo_q.push_back(w);
  endtask : push

  // words change at the falling edge; out of reset an idle bus inverts the word on every idle falling edge
  always @(negedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      word_valid <= 1'b0;
    end
    else if (wait_n > 0 || fifo_q.size() == 0)
    begin
      if (wait_n > 0)
        wait_n = wait_n - 1;
      word_valid <= 1'b0;
      instr_word <= ~instr_word;
    end
    else
    begin
      instr_word <= fifo_q.pop_front();
      word_valid <= 1'b1;
      wait_n = stall;
    end
  end
endmodule : prog_mem_model

// file: bench/dsp_opcode_decoder_a_to_l_tb.sv
// dsp_opcode_decoder_a_to_l_tb: self-checking bench for the opcode decoder
// assumes the program memory model feeds words; flags are driven here at the falling edge
`timescale 1ns/1ns
module dsp_opcode_decoder_a_to_l_tb;
  logic                 ref_clk = 1'b0;
  logic                 rst = 1'b1;
  logic [15:0]          instr_word;
  logic                 word_valid;
  logic                 acc_zero = 1'b0, acc_neg = 1'b0, ovf = 1'b0, carry = 1'b0;
  logic                 test_flag = 1'b0, aux_nonzero = 1'b0, branch_pin = 1'b1;
  opdec_pkg::op_class_e op_class_q;
  logic                 dec_valid_q, branch_taken_q, indirect_q, sets_test_flag_q;
  logic [1:0]           word_count_q, compare_sel_q;
  logic [2:0]           cycle_count_q;
  logic [3:0]           shift_q, bit_sel_q;
  logic [7:0]           imm_q;
  logic [6:0]           addr_q;
  logic [15:0]          operand_q;
  int                   err_total = 0, n_tests = 0, n_dec = 0, cyc_n = 0;

  // decoder under test and its program memory
  opcode_decoder opcode_decoder_i (.ref_clk(ref_clk), .rst(rst), .instr_word(instr_word),
    .word_valid(word_valid), .acc_zero(acc_zero), .acc_neg(acc_neg), .ovf(ovf),
    .carry(carry), .test_flag(test_flag), .aux_nonzero(aux_nonzero),
    .branch_pin(branch_pin), .op_class_q(op_class_q), .dec_valid_q(dec_valid_q),
    .word_count_q(word_count_q), .cycle_count_q(cycle_count_q),
    .branch_taken_q(branch_taken_q), .shift_q(shift_q), .imm_q(imm_q),
    .indirect_q(indirect_q), .addr_q(addr_q), .operand_q(operand_q),
    .bit_sel_q(bit_sel_q), .compare_sel_q(compare_sel_q),
    .sets_test_flag_q(sets_test_flag_q));
  prog_mem_model prog_mem_model_i (.ref_clk(ref_clk), .rst(rst), .instr_word(instr_word),
    .word_valid(word_valid));

  // clock, decode pulse counter and hang guard
  always #20 ref_clk = ~ref_clk;
  always @(negedge ref_clk)
    if (dec_valid_q === 1'b1)
      n_dec = n_dec + 1;
  always @(posedge ref_clk)
  begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 8000)
    begin
      err_total = err_total + 1;
      final_report();
    end
  end

  // verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // compare a vector result
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  // compare an operation class
  task automatic chk_cls(input opdec_pkg::op_class_e exp, input opdec_pkg::op_class_e got);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch op_class expected %s seen %s", exp.name(), got.name());
    end
  endtask : chk_cls

  // expected condition outcome from selector pair, mask and wanted states
  function automatic logic cexp(input logic [15:0] w);
    logic s;
    case (w[9:8])
      2'h0:    s = ~branch_pin;
      2'h1:    s = test_flag;
      2'h2:    s = ~test_flag;
      default: s = 1'b0;
    endcase
    return s | (|(w[3:0] & ~(w[7:4] ^ {acc_zero, acc_neg, ovf, carry})));
  endfunction : cexp

  // one instruction: feed words, await the single decode pulse, check the summary
  task automatic dec(input logic [15:0] w0, input logic [15:0] w1, input logic two,
                     input opdec_pkg::op_class_e cls, input logic [2:0] cyc, input logic tk);
    int n0;
    int k;
    @(negedge ref_clk);
    #1;
    n0 = n_dec;
    k  = 0;
    prog_mem_model_i.push(w0);
    if (two)
      prog_mem_model_i.push(w1);
    do
    begin
      @(negedge ref_clk);
      k = k + 1;
    end
    while (dec_valid_q !== 1'b1 && k < 30);
    chk_val("dec_valid", 16'h0001, {15'h0000, dec_valid_q});
    chk_cls(cls, op_class_q);
    chk_val("word_count", two ? 16'h0002 : 16'h0001, {14'h0000, word_count_q});
    chk_val("cycle_count", {13'h0000, cyc}, {13'h0000, cycle_count_q});
    chk_val("branch_taken", {15'h0000, tk}, {15'h0000, branch_taken_q});
    chk_val("operand", two ? w1 : 16'h0000, operand_q);
    repeat (4) @(negedge ref_clk);
    #1;
    chk_val("decode_pulses", 16'h0001, 16'(n_dec - n0));
  endtask : dec

  // flag levels change at the falling edge
  task automatic set_flags(input logic [3:0] f, input logic tf, input logic pin);
    @(negedge ref_clk);
    {acc_zero, acc_neg, ovf, carry} = f;
    test_flag  = tf;
    branch_pin = pin;
    repeat (3) @(negedge ref_clk);
  endtask : set_flags

  // sum_unsigned_low_op, magnitude, product and accumulator branch
  task automatic t_arith;
    dec(16'hbe00, 16'h0000, 1'b0, opdec_pkg::OPC_MAGNITUDE, 3'h1, 1'b0);
    dec(16'h2a85, 16'h0000, 1'b0, opdec_pkg::OPC_ADD_SHIFT, 3'h1, 1'b0);
    chk_val("shift", 16'h000a, {12'h000, shift_q});
    chk_val("indirect_addr", 16'h0085, {8'h00, indirect_q, addr_q});
    dec(16'h6103, 16'h0000, 1'b0, opdec_pkg::OPC_ADD_HIGH, 3'h1, 1'b0);
    dec(16'hb87f, 16'h0000, 1'b0, opdec_pkg::OPC_ADD_IMM, 3'h1, 1'b0);
    chk_val("imm", 16'h007f, {8'h00, imm_q});
    dec(16'hbf93, 16'h1234, 1'b1, opdec_pkg::OPC_ADD_LONG, 3'h2, 1'b0);
    chk_val("shift", 16'h0003, {12'h000, shift_q});
    dec(16'h6011, 16'h0000, 1'b0, opdec_pkg::OPC_SUM_CARRY, 3'h1, 1'b0);
    dec(16'h6211, 16'h0000, 1'b0, opdec_pkg::OPC_SUM_LOW, 3'h1, 1'b0);
    dec(16'h6311, 16'h0000, 1'b0, opdec_pkg::OPC_SUM_TSHIFT, 3'h1, 1'b0);
    dec(16'h7822, 16'h0000, 1'b0, opdec_pkg::OPC_AUX_OFFSET, 3'h1, 1'b0);
    chk_val("imm", 16'h0022, {8'h00, imm_q});
    dec(16'h6e01, 16'h0000, 1'b0, opdec_pkg::OPC_AND_MEM, 3'h1, 1'b0);
    dec(16'hbfb4, 16'habcd, 1'b1, opdec_pkg::OPC_AND_LONG, 3'h2, 1'b0);
    chk_val("shift", 16'h0004, {12'h000, shift_q});
    dec(16'hbe81, 16'h5555, 1'b1, opdec_pkg::OPC_AND_HI16, 3'h2, 1'b0);
    dec(16'hbe04, 16'h0000, 1'b0, opdec_pkg::OPC_PRODUCT_ACC, 3'h1, 1'b0);
    dec(16'hbe20, 16'h0000, 1'b0, opdec_pkg::OPC_ACC_BRANCH, 3'h4, 1'b1);
  endtask : t_arith

  // aux loop branch, accumulator conditions, pin and test flag selectors
  task automatic t_branch;
    logic [15:0] codes[10] = '{16'he38c, 16'he304, 16'he3cc, 16'he344, 16'he322,
                               16'he302, 16'he311, 16'he301, 16'he388, 16'he308};
    logic [3:0]  fl[3] = '{4'h0, 4'hf, 4'h5};
    logic        t;
    aux_nonzero = 1'b1;
    dec(16'h7b80, 16'h0100, 1'b1, opdec_pkg::OPC_AUX_LOOP, 3'h4, 1'b1);
    aux_nonzero = 1'b0;
    dec(16'h7b80, 16'h0100, 1'b1, opdec_pkg::OPC_AUX_LOOP, 3'h2, 1'b0);
    foreach (fl[j])
    begin
      set_flags(fl[j], j[0], ~j[1]);
      foreach (codes[i])
      begin
        t = cexp(codes[i]);
        dec(codes[i], 16'h0200, 1'b1, opdec_pkg::OPC_COND_BRANCH, t ? 3'h4 : 3'h2, t);
      end
    end
    for (int p = 0; p < 2; p++)
    begin
      set_flags(4'h0, p[0], p[0]);
      t = cexp(16'he000);
      dec(16'he000, 16'h0300, 1'b1, opdec_pkg::OPC_COND_BRANCH, t ? 3'h4 : 3'h3, t);
      t = cexp(16'he100);
      dec(16'he100, 16'h0301, 1'b1, opdec_pkg::OPC_COND_BRANCH, t ? 3'h4 : 3'h2, t);
      t = cexp(16'he200);
      dec(16'he200, 16'h0302, 1'b1, opdec_pkg::OPC_COND_BRANCH, t ? 3'h4 : 3'h2, t);
    end
  endtask : t_branch

  // bit tests, compare, data copies and port read from a slow memory
  task automatic t_misc;
    dec(16'h6f05, 16'h0000, 1'b0, opdec_pkg::OPC_DYN_TEST, 3'h1, 1'b0);
    chk_val("sets_tf", 16'h0001, {15'h0000, sets_test_flag_q});
    dec(16'h4a05, 16'h0000, 1'b0, opdec_pkg::OPC_BIT_TEST, 3'h1, 1'b0);
    chk_val("bit_sel", 16'h000a, {12'h000, bit_sel_q});
    dec(16'hbf46, 16'h0000, 1'b0, opdec_pkg::OPC_AUX_COMPARE, 3'h1, 1'b0);
    chk_val("cmp_sel_tf", 16'h0005, {13'h0000, compare_sel_q, sets_test_flag_q});
    prog_mem_model_i.stall = 3;
    // copies use plain data addresses, never the interrupt or allocation registers
    dec(16'ha805, 16'h0300, 1'b1, opdec_pkg::OPC_COPY_SRC, 3'h3, 1'b0);
    chk_val("addr", 16'h0005, {9'h000, addr_q});
    dec(16'ha985, 16'h0310, 1'b1, opdec_pkg::OPC_COPY_DST, 3'h3, 1'b0);
    dec(16'haf10, 16'h1234, 1'b1, opdec_pkg::OPC_PORT_READ, 3'h2, 1'b0);
    prog_mem_model_i.stall = 0;
  endtask : t_misc

  // operand word that looks like an opcode, then two one-word ops back to back
  task automatic t_back2back;
    dec(16'hbf93, 16'hbe00, 1'b1, opdec_pkg::OPC_ADD_LONG, 3'h2, 1'b0);
    prog_mem_model_i.push(16'hbe04);
    prog_mem_model_i.push(16'hbe00);
    repeat (2) @(negedge ref_clk);
    chk_cls(opdec_pkg::OPC_PRODUCT_ACC, op_class_q);
    @(negedge ref_clk);
    chk_cls(opdec_pkg::OPC_MAGNITUDE, op_class_q);
    chk_val("dec_valid", 16'h0001, {15'h0000, dec_valid_q});
  endtask : t_back2back

  // reset, then every scenario in turn
  initial
  begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk_cls(opdec_pkg::OPC_NONE, op_class_q);
    t_arith();
    t_branch();
    t_misc();
    t_back2back();
    final_report();
  end
endmodule : dsp_opcode_decoder_a_to_l_tb
